// *** shared/pwm_cfg.svh ***
// register offsets, field positions and reset values of the pwm configuration block
// assumes a 32-bit AXI4-Lite slave, one register per aligned word
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH

// ****************************************
// register indices, byte address is index times four
// ****************************************
`define CTL_INDEX    10'h089
`define COUNT_INDEX  10'h08a
`define OPT_INDEX    10'h091
`define PRDH_INDEX   10'h092
`define PRDL_INDEX   10'h093

// ****************************************
// field positions
// ****************************************
`define CTL_GATE_BIT 7
`define CTL_MODE_HI  5
`define CTL_MODE_LO  4
`define CTL_GAP_HI   3
`define CTL_GAP_LO   0
`define OPT_SRC_HI   5
`define OPT_SRC_LO   4

// ****************************************
// reset values and responses
// ****************************************
`define CTL_RESET    8'h00
`define OPT_RESET    8'h00
`define PRDH_RESET   8'hff
`define PRDL_RESET   8'hff
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// *** shared/pwm_pkg.sv ***
// types shared by the pwm configuration block and its waveform core
// assumes nothing beyond a SystemVerilog compiler
package pwm_pkg;

  typedef enum logic [1:0] {
    MODE_ZERO  = 2'b00,
    MODE_ONE   = 2'b01,
    MODE_TWO   = 2'b10,
    MODE_THREE = 2'b11
  } out_mode_type;

  typedef enum logic [1:0] {
    SRC_SYS_A  = 2'b00,
    SRC_SYS_B  = 2'b01,
    SRC_FAST   = 2'b10,
    SRC_FAST2  = 2'b11
  } clk_src_type;

  typedef enum logic {
    PHASE_RUN = 1'b0,
    PHASE_GAP = 1'b1
  } phase_type;

endpackage : pwm_pkg

// *** shared/pwm_link_if.sv ***
// signals between the register block and the waveform core
// assumes both ends run on clk_sys
interface pwm_link_if;
  logic                     tick;
  logic                     gate;
  pwm_pkg::out_mode_type    mode;
  logic [3:0]               gap;
  logic [15:0]              period;
  logic [15:0]              duty;
  logic                     out_a;
  logic                     out_b;
  logic [15:0]              count;

  modport ctrl (output tick, gate, mode, gap, period, duty, input out_a, out_b, count);
  modport core (input tick, gate, mode, gap, period, duty, output out_a, out_b, count);
endinterface : pwm_link_if

// *** rtl/pwm_wave_core.sv ***
// channel 0 period counter, compare, non-overlap gap and output mode
// assumes tick, gate and settings come from logic on clk_sys
module pwm_wave_core (
  // clock and reset
  input  wire logic  clk_sys,
  input  wire logic  resetn,
  // settings and outputs
  pwm_link_if.core   lnk
);
  import pwm_pkg::*;

  // ****************************************
  // next-state decode
  // ****************************************
  logic [15:0] cnt_reg;
  logic        level_reg;
  phase_type   phase_reg;
  logic [3:0]  gap_cnt_reg;
  logic        out_a_reg;
  logic        out_b_reg;

  wire         step       = lnk.gate & lnk.tick;
  wire         wrap       = (cnt_reg >= lnk.period);
  wire [15:0]  cnt_next   = !step ? cnt_reg : (wrap ? 16'h0000 : cnt_reg + 16'h0001);
  wire         level_next = step ? (cnt_reg < lnk.duty) : level_reg;
  wire         edge_seen  = step & (level_next != level_reg);
  wire         gap_start  = edge_seen & (lnk.gap != 4'h0);
  wire         gap_done   = (phase_reg == PHASE_GAP) & step & (gap_cnt_reg == 4'h1);
  wire         run_next   = !gap_start & ((phase_reg == PHASE_RUN) | gap_done) & lnk.gate;
  phase_type   phase_next;
  logic        mode_a;
  logic        mode_b;

  always_comb begin
    phase_next = phase_reg;
    if (!lnk.gate) begin
      phase_next = PHASE_RUN;
    end else if (gap_start) begin
      phase_next = PHASE_GAP;
    end else if (gap_done) begin
      phase_next = PHASE_RUN;
    end
  end

  always_comb begin
    case (lnk.mode)
      MODE_ZERO: begin
        mode_a = level_next;
        mode_b = !level_next;
      end
      MODE_ONE: begin
        mode_a = !level_next;
        mode_b = level_next;
      end
      MODE_TWO: begin
        mode_a = level_next;
        mode_b = level_next;
      end
      MODE_THREE: begin
        mode_a = level_next;
        mode_b = 1'b0;
      end
      default: begin
        mode_a = 1'b0;
        mode_b = 1'b0;
      end
    endcase
  end

  wire [3:0] gap_cnt_next = gap_start ? lnk.gap :
                            ((phase_reg == PHASE_GAP) & step) ? gap_cnt_reg - 4'h1 : gap_cnt_reg;

  // ****************************************
  // state
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_reg     <= 16'h0000;
      level_reg   <= 1'b0;
      phase_reg   <= PHASE_RUN;
      gap_cnt_reg <= 4'h0;
      out_a_reg   <= 1'b0;
      out_b_reg   <= 1'b0;
    end else begin
      cnt_reg     <= cnt_next;
      level_reg   <= level_next;
      phase_reg   <= phase_next;
      gap_cnt_reg <= gap_cnt_next;
      out_a_reg   <= run_next & mode_a;
      out_b_reg   <= run_next & mode_b;
    end
  end

  assign lnk.out_a = out_a_reg;
  assign lnk.out_b = out_b_reg;
  assign lnk.count = cnt_reg;

  // ****************************************
  // checks
  // ****************************************
  counter_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !lnk.gate |=> cnt_reg == $past(cnt_reg))
    else $error("counter moved while clock gated");

  gap_load_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    gap_start |=> phase_reg == PHASE_GAP && gap_cnt_reg == $past(lnk.gap) && !out_a_reg && !out_b_reg)
    else $error("gap not entered with its width");

  single_output_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    lnk.mode == MODE_THREE |=> !out_b_reg)
    else $error("second output active in mode three");

  gap_seen_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    phase_reg == PHASE_GAP ##1 phase_reg == PHASE_RUN && out_a_reg);

  wrap_seen_c: cover property (@(posedge clk_sys) disable iff (!resetn) step && wrap);

endmodule : pwm_wave_core

// *** rtl/pwm_clock_deadzone_config.sv ***
// AXI4-Lite register block of the pwm configuration with its waveform core
// assumes fast_osc_clk comes from outside the clk_sys domain, duty0 from clk_sys logic
`include "pwm_cfg.svh"

module pwm_clock_deadzone_config (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // AXI4-Lite write address and data
  input  wire logic [11:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // modulation clock source and duty
  input  wire logic         fast_osc_clk,
  input  wire logic [15:0]  duty0,
  // channel 0 outputs and period
  output logic              pwm0_out_a,
  output logic              pwm0_out_b,
  output logic [15:0]       period_value
);
  import pwm_pkg::*;

  function automatic logic hit(input logic [11:0] addr, input logic [9:0] index);
    hit = (addr[11:2] == index);
  endfunction : hit

  function automatic logic mapped(input logic [11:0] addr);
    mapped = hit(addr, `CTL_INDEX) | hit(addr, `COUNT_INDEX) | hit(addr, `OPT_INDEX) |
             hit(addr, `PRDH_INDEX) | hit(addr, `PRDL_INDEX);
  endfunction : mapped

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]  ctl_reg;
  logic [7:0]  opt_reg;
  logic [7:0]  prdh_reg;
  logic [7:0]  prdl_reg;
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        osc_s1_reg;
  logic        osc_s2_reg;
  logic        osc_s3_reg;
  logic        tick_reg;

  pwm_link_if lnk ();

  // ****************************************
  // write path
  // ****************************************
  wire aw_take    = s_axi_awvalid & s_axi_awready;
  wire w_take     = s_axi_wvalid & s_axi_wready;
  wire do_write   = aw_full_reg & w_full_reg & !s_axi_bvalid;
  wire aw_full_nx = (aw_full_reg | aw_take) & !do_write;
  wire w_full_nx  = (w_full_reg | w_take) & !do_write;
  wire lane0      = do_write & w_strb_reg[0];
  wire wr_ctl     = lane0 & hit(aw_addr_reg, `CTL_INDEX);
  wire wr_opt     = lane0 & hit(aw_addr_reg, `OPT_INDEX);
  wire wr_prdh    = lane0 & hit(aw_addr_reg, `PRDH_INDEX);
  wire wr_prdl    = lane0 & hit(aw_addr_reg, `PRDL_INDEX);
  wire [7:0] opt_mask = 8'h30;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      aw_addr_reg   <= 12'h000;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      aw_full_reg   <= aw_full_nx;
      w_full_reg    <= w_full_nx;
      s_axi_awready <= !aw_full_nx;
      s_axi_wready  <= !w_full_nx;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctl_reg  <= `CTL_RESET;
      opt_reg  <= `OPT_RESET;
      prdh_reg <= `PRDH_RESET;
      prdl_reg <= `PRDL_RESET;
    end else begin
      if (wr_ctl) begin
        ctl_reg <= w_data_reg[7:0] & 8'hbf;
      end
      if (wr_opt) begin
        opt_reg <= w_data_reg[7:0] & opt_mask;
      end
      if (wr_prdh) begin
        prdh_reg <= w_data_reg[7:0];
      end
      if (wr_prdl) begin
        prdl_reg <= w_data_reg[7:0];
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  wire        ar_take = s_axi_arvalid & s_axi_arready;
  wire        rv_next = ar_take | (s_axi_rvalid & !s_axi_rready);
  wire [31:0] rd_mux  = hit(s_axi_araddr, `CTL_INDEX)   ? {24'h000000, ctl_reg}  :
                        hit(s_axi_araddr, `COUNT_INDEX) ? {16'h0000, lnk.count}  :
                        hit(s_axi_araddr, `OPT_INDEX)   ? {24'h000000, opt_reg}  :
                        hit(s_axi_araddr, `PRDH_INDEX)  ? {24'h000000, prdh_reg} :
                        hit(s_axi_araddr, `PRDL_INDEX)  ? {24'h000000, prdl_reg} : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_rvalid  <= rv_next;
      s_axi_arready <= !rv_next;
      if (ar_take) begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // modulation clock source
  // ****************************************
  wire [1:0] src_code = opt_reg[`OPT_SRC_HI:`OPT_SRC_LO];
  wire       osc_rise = osc_s2_reg & !osc_s3_reg;
  wire       osc_any  = osc_s2_reg ^ osc_s3_reg;
  wire       tick_nx  = !src_code[1] ? 1'b1 : (src_code[0] ? osc_any : osc_rise);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
      tick_reg   <= 1'b0;
    end else begin
      osc_s1_reg <= fast_osc_clk;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      tick_reg   <= tick_nx;
    end
  end

  // ****************************************
  // waveform core
  // ****************************************
  assign lnk.tick   = tick_reg;
  assign lnk.gate   = ctl_reg[`CTL_GATE_BIT];
  assign lnk.mode   = out_mode_type'(ctl_reg[`CTL_MODE_HI:`CTL_MODE_LO]);
  assign lnk.gap    = ctl_reg[`CTL_GAP_HI:`CTL_GAP_LO];
  assign lnk.period = {prdh_reg, prdl_reg};
  assign lnk.duty   = duty0;

  pwm_wave_core u_core (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .lnk     (lnk.core)
  );

  assign pwm0_out_a   = lnk.out_a;
  assign pwm0_out_b   = lnk.out_b;
  assign period_value = {prdh_reg, prdl_reg};

  // ****************************************
  // checks
  // ****************************************
  gate_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !ctl_reg[`CTL_GATE_BIT] |=> !pwm0_out_a && !pwm0_out_b)
    else $error("output active while clock gated");

  sys_tick_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !src_code[1] |=> tick_reg)
    else $error("system clock source gave no tick");

  prdh_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_prdh |=> prdh_reg == $past(w_data_reg[7:0]) && s_axi_bvalid)
    else $error("upper period byte not written");

  prdl_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_prdl |=> period_value[7:0] == $past(w_data_reg[7:0]))
    else $error("lower period byte not written");

  write_done_c: cover property (@(posedge clk_sys) disable iff (!resetn) wr_ctl ##1 s_axi_bvalid);

  read_done_c: cover property (@(posedge clk_sys) disable iff (!resetn) ar_take ##1 s_axi_rvalid);

endmodule : pwm_clock_deadzone_config

// *** test/pwm_load_model.sv ***
// load on the channel 0 outputs: counts high and both-low cycles in a window
// assumes outputs are registers on clk_sys and watch/clear come from the bench
module pwm_load_model (
  // clock and window control
  input  wire logic        clk_sys,
  input  wire logic        watch,
  input  wire logic        clear,
  // driven switch lines
  input  wire logic        out_a,
  input  wire logic        out_b,
  // cycle counts of the last window
  output logic [15:0]      n_ahi,
  output logic [15:0]      n_bhi,
  output logic [15:0]      n_low
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // window counters
  // ****************************************
  always @(posedge clk_sys) begin
    if (clear) begin
      n_ahi <= 16'h0000;
      n_bhi <= 16'h0000;
      n_low <= 16'h0000;
    end else if (watch) begin
      n_ahi <= n_ahi + {15'h0000, out_a};
      n_bhi <= n_bhi + {15'h0000, out_b};
      n_low <= n_low + {15'h0000, !out_a && !out_b};
    end
  end
endmodule : pwm_load_model

// *** test/testbench.sv ***
// self-checking bench: AXI4-Lite register tasks and output window checks
// assumes the load model counts output cycles while watch is high
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // signals
  // ****************************************
  logic clk_sys, resetn, fast_osc_clk, osc_run, watch, clear;
  logic [11:0] awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, out_a, out_b;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rdat, c1, c2;
  logic [15:0] duty0, period_value, n_ahi, n_bhi, n_low;
  logic [1:0]  osc_cnt;
  int          n_errors, checks_done, i;
  logic [15:0] e_a[4] = '{16'h0014, 16'h001e, 16'h0014, 16'h0014};
  logic [15:0] e_b[4] = '{16'h001e, 16'h0014, 16'h0014, 16'h0000};
  logic [15:0] e_l[4] = '{16'h0000, 16'h0000, 16'h001e, 16'h001e};
  logic [7:0]  g_c[3] = '{8'h80, 8'h81, 8'h8f};
  logic [15:0] g_l[3] = '{16'h0000, 16'h0002, 16'h001e};

  pwm_clock_deadzone_config pwm_clock_deadzone_config_i (
    .clk_sys(clk_sys), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fast_osc_clk(fast_osc_clk), .duty0(duty0),
    .pwm0_out_a(out_a), .pwm0_out_b(out_b), .period_value(period_value));

  pwm_load_model pwm_load_model_i (
    .clk_sys(clk_sys), .watch(watch), .clear(clear), .out_a(out_a), .out_b(out_b),
    .n_ahi(n_ahi), .n_bhi(n_bhi), .n_low(n_low));

  // ****************************************
  // clock and oscillator
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (osc_run) begin
      osc_cnt      <= (osc_cnt == 2'h2) ? 2'h0 : osc_cnt + 2'h1;
      fast_osc_clk <= (osc_cnt == 2'h2) ? ~fast_osc_clk : fast_osc_clk;
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      n_errors++;
    end
  endtask : chk

  task hang;
    n_errors++;
    $display("ERROR bus wait expected answer seen none");
    give_verdict();
  endtask : hang

  task wr(input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_sys);
    awaddr <= a; wdata <= {24'h000000, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (k == 64) hang();
  endtask : wr

  task rd(input logic [11:0] a);
    int k;
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rdat = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (k == 64) hang();
  endtask : rd

  task window(input int n);
    @(posedge clk_sys);
    clear <= 1'b1;
    @(posedge clk_sys);
    clear <= 1'b0;
    watch <= 1'b1;
    repeat (n) @(posedge clk_sys);
    watch <= 1'b0;
    @(posedge clk_sys);
  endtask : window

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    resetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; wstrb = 4'h1;
    fast_osc_clk = 1'b0; osc_run = 1'b0; osc_cnt = 2'h0; watch = 1'b0; clear = 1'b0;
    duty0 = 16'h0004; n_errors = 0; checks_done = 0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(12'h224); chk("ctl reset", rdat, 32'h0);
    rd(12'h244); chk("options reset", rdat, 32'h0);
    rd(12'h248); chk("period high reset", rdat, 32'hff);
    rd(12'h24c); chk("period low reset", rdat, 32'hff);
    chk("period value reset", {16'h0, period_value}, 32'hffff);
    $display("test reset values done");
    wr(12'h224, 8'hff); rd(12'h224); chk("ctl rw", rdat, 32'hbf);
    wr(12'h244, 8'hff); rd(12'h244); chk("options rw", rdat, 32'h30);
    wr(12'h244, 8'h00); wr(12'h224, 8'h00);
    wr(12'h248, 8'h00); rd(12'h248); chk("period high rw", rdat, 32'h0);
    wstrb <= 4'h0;
    wr(12'h248, 8'h5a); chk("strobe off resp", {30'h0, resp}, 32'h0);
    wstrb <= 4'h1;
    rd(12'h248); chk("strobe off keeps", rdat, 32'h0);
    wr(12'h24c, 8'h09); rd(12'h24c); chk("period low rw", rdat, 32'h9);
    chk("period value", {16'h0, period_value}, 32'h0009);
    wr(12'h3fc, 8'h55); chk("unmapped write resp", {30'h0, resp}, 32'h2);
    rd(12'h3fc); chk("unmapped read resp", {30'h0, resp}, 32'h2);
    $display("test register access done");
    for (i = 0; i < 4; i++) begin
      wr(12'h224, 8'h80 | 8'(i << 4));
      repeat (20) @(posedge clk_sys);
      window(50);
      chk("mode a high", {16'h0, n_ahi}, {16'h0, e_a[i]});
      chk("mode b high", {16'h0, n_bhi}, {16'h0, e_b[i]});
      chk("mode both low", {16'h0, n_low}, {16'h0, e_l[i]});
    end
    $display("test output modes done");
    duty0 <= 16'h0028;
    wr(12'h24c, 8'h63);
    for (i = 0; i < 3; i++) begin
      wr(12'h224, g_c[i]);
      repeat (110) @(posedge clk_sys);
      window(100);
      chk("gap both low", {16'h0, n_low}, {16'h0, g_l[i]});
    end
    $display("test gap widths done");
    for (i = 2; i < 4; i++) begin
      osc_run <= 1'b0;
      wr(12'h244, 8'(i << 4));
      rd(12'h228); c1 = rdat;
      repeat (10) @(posedge clk_sys);
      rd(12'h228); chk("count held osc idle", rdat, c1);
      osc_run <= 1'b1;
      repeat (40) @(posedge clk_sys);
      rd(12'h228); chk("count runs on osc", {31'h0, rdat !== c1}, 32'h1);
    end
    osc_run <= 1'b0;
    wr(12'h244, 8'h10);
    rd(12'h228); c1 = rdat;
    repeat (10) @(posedge clk_sys);
    rd(12'h228); chk("count runs on sys clock", {31'h0, rdat !== c1}, 32'h1);
    wr(12'h244, 8'h00);
    $display("test clock source done");
    wr(12'h224, 8'h00);
    rd(12'h228); c2 = rdat;
    repeat (20) @(posedge clk_sys);
    rd(12'h228); chk("count held gate off", rdat, c2);
    window(20); chk("outputs idle gate off", {16'h0, n_low}, 32'h14);
    $display("test clock gate done");
    give_verdict();
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    hang();
  end
endmodule : testbench
